// File: core/scm_pkg.sv
/*
  Constants for the sensor command mailbox: command encodings, reply codes,
  field positions and reset values.
  Assumes a single 40 MHz sequencer clock and an active-high asynchronous reset.
*/
// Behaviour
// - Code 111+index ORs host value into parameter, stores it, copies to readback.
// - Null command 000 00000 sets reply and counter to zero and clears a held error.
// - Code 000 00001 performs a software reset of sequencer state.
// - Code 000 00010 changes slave address; no mailbox use, no error reply.
// - Code 000 00101 runs one proximity pass, then updates reply.
// - Code 000 00110 runs one ambient pass, then updates reply.
// - Code 000 00111 runs proximity pass, then ambient pass unless proximity overflowed, then updates reply.
// - Code 000 01101 starts proximity loop; 000 01001 halts it.
// - Code 000 01110 starts ambient loop; 000 01010 halts it.
// - Code 000 01111 starts both loops; 000 01011 halts both.
// - Without error, upper nibble zero, lower nibble counts completions, wrapping.
// - Null command resets the completion counter to zero.
// - Invalid setting writes 1000 0000, held until null or software reset command.
// - Proximity channel 1/2/3 overflow writes 1000 1000/1001/1010.
// - Visible/infrared/auxiliary overflow writes 1000 1100/1101/1110.
// - Codes 100/101/110+index read, set, AND parameter; result to readback.
package scm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command field layout
  localparam int OP_MSB = 7;
  localparam int OP_LSB = 5;
  localparam int IDX_MSB = 4;
  localparam int IDX_LSB = 0;
  localparam logic [2:0] OP_MISC = 3'h0;
  localparam logic [2:0] OP_QUERY = 3'h4;
  localparam logic [2:0] OP_SET = 3'h5;
  localparam logic [2:0] OP_AND = 3'h6;
  localparam logic [2:0] OP_OR = 3'h7;

  // Miscellaneous command codes
  localparam logic [7:0] NULL_CMD = 8'h00;
  localparam logic [7:0] SOFT_RESET_CMD = 8'h01;
  localparam logic [7:0] BUS_ADDRESS_CHANGE_CMD = 8'h02;
  localparam logic [7:0] SINGLE_PROXIMITY_CMD = 8'h05;
  localparam logic [7:0] SINGLE_AMBIENT_CMD = 8'h06;
  localparam logic [7:0] SINGLE_BOTH_CMD = 8'h07;
  localparam logic [7:0] PROXIMITY_HALT_CMD = 8'h09;
  localparam logic [7:0] AMBIENT_HALT_CMD = 8'h0a;
  localparam logic [7:0] BOTH_HALT_CMD = 8'h0b;
  localparam logic [7:0] PROXIMITY_LOOP_CMD = 8'h0d;
  localparam logic [7:0] AMBIENT_LOOP_CMD = 8'h0e;
  localparam logic [7:0] BOTH_LOOP_CMD = 8'h0f;

  ////////////////////////////////////////////////////////////////////////////
  // Reply codes
  localparam logic [7:0] REPLY_RESET = 8'h00;
  localparam logic [7:0] REPLY_INVALID_SETTING = 8'h80;
  localparam logic [7:0] REPLY_PROX_CH1_SATURATED = 8'h88;
  localparam logic [7:0] REPLY_PROX_CH2_SATURATED = 8'h89;
  localparam logic [7:0] REPLY_PROX_CH3_SATURATED = 8'h8a;
  localparam logic [7:0] REPLY_VISIBLE_SATURATED = 8'h8c;
  localparam logic [7:0] REPLY_INFRARED_SATURATED = 8'h8d;
  localparam logic [7:0] REPLY_AUX_SATURATED = 8'h8e;
  localparam logic [3:0] ERROR_NIBBLE = 4'h8;

  // Reset values
  localparam logic [7:0] PARAM_RESET = 8'h00;
  localparam logic [7:0] READBACK_RESET = 8'h00;
  localparam logic [6:0] BUS_ADDRESS_RESET = 7'h5a;

  // Sequencer states
  typedef enum logic [4:0] {
    SCM_IDLE = 5'b00001,
    SCM_PROX = 5'b00010,
    SCM_AMB = 5'b00100,
    SCM_DONE = 5'b01000,
    SCM_ERR = 5'b10000
  } scm_state_t;

endpackage

// File: core/scm_mailbox.sv
/*
  Command decoder and reply generator of the sensor sequencer.
  Assumes the register front end gives a one-cycle command write strobe with the
  code and host value box held, and that the measurement engine answers each
  pass request with a one-cycle done pulse and overflow flags.
*/
`timescale 1ns/100ps
`default_nettype none
module scm_mailbox #(
  parameter int PARAM_COUNT = 32
) (
  input wire logic clk, // 40 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic cmd_write, // Pulse: command register written
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [7:0] host_value_box, // Host value mailbox
  input wire logic [6:0] new_bus_address, // Address for the address change
  input wire logic invalid_setting, // Pulse: invalid setting found
  input wire logic meas_done, // Pulse: requested pass finished
  input wire logic [5:0] meas_saturated, // Overflow flags with meas_done
  output logic [7:0] reply, // Reply register
  output logic [7:0] readback_box, // Readback mailbox
  output logic [6:0] bus_address, // Current slave address
  output logic prox_pass_req, // Level: proximity pass requested
  output logic amb_pass_req, // Level: ambient pass requested
  output logic prox_loop_en, // Autonomous proximity loop running
  output logic amb_loop_en, // Autonomous ambient loop running
  output logic soft_reset_pulse, // Pulse: sequencer software reset
  output logic busy // Command in progress
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic [2:0] op;
  logic [4:0] idx;
  logic [7:0] param_mem [PARAM_COUNT];
  logic [7:0] param_val;
  logic [7:0] param_new;
  logic is_param;
  logic accept;
  scm_pkg::scm_state_t state_r;
  scm_pkg::scm_state_t state_nxt;
  logic both_r;
  logic quiet_r;
  logic [7:0] err_code;
  logic err_seen;
  logic [3:0] count_r;
  logic err_hold_r;

  assign op = cmd_code[scm_pkg::OP_MSB:scm_pkg::OP_LSB];
  assign idx = cmd_code[scm_pkg::IDX_MSB:scm_pkg::IDX_LSB];
  assign param_val = param_mem[idx];
  assign is_param = op[2];
  // Only a command register write starts work, and only when idle
  assign accept = cmd_write && (state_r == scm_pkg::SCM_IDLE);
  assign busy = (state_r != scm_pkg::SCM_IDLE);

  // Parameter result per operation
  always_comb
  begin
    unique case (op)
      scm_pkg::OP_SET: param_new = host_value_box;
      scm_pkg::OP_AND: param_new = param_val & host_value_box;
      scm_pkg::OP_OR: param_new = param_val | host_value_box;
      default: param_new = param_val;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter store, no reset on the array
  always_ff @(posedge clk)
  begin
    if (accept && is_param && op != scm_pkg::OP_QUERY)
      param_mem[idx] <= param_new;
  end

  // Readback box
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      readback_box <= scm_pkg::READBACK_RESET;
    else if (accept && is_param)
      readback_box <= param_new;
  end

  // Slave address
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      bus_address <= scm_pkg::BUS_ADDRESS_RESET;
    else if (accept && cmd_code == scm_pkg::BUS_ADDRESS_CHANGE_CMD)
      bus_address <= new_bus_address;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Autonomous loop enables; reserved codes fall through untouched
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prox_loop_en <= 1'b0;
      amb_loop_en <= 1'b0;
    end
    else if (accept)
    begin
      unique case (cmd_code)
        scm_pkg::SOFT_RESET_CMD:
        begin
          prox_loop_en <= 1'b0;
          amb_loop_en <= 1'b0;
        end
        scm_pkg::PROXIMITY_LOOP_CMD: prox_loop_en <= 1'b1;
        scm_pkg::PROXIMITY_HALT_CMD: prox_loop_en <= 1'b0;
        scm_pkg::AMBIENT_LOOP_CMD: amb_loop_en <= 1'b1;
        scm_pkg::AMBIENT_HALT_CMD: amb_loop_en <= 1'b0;
        scm_pkg::BOTH_LOOP_CMD:
        begin
          prox_loop_en <= 1'b1;
          amb_loop_en <= 1'b1;
        end
        scm_pkg::BOTH_HALT_CMD:
        begin
          prox_loop_en <= 1'b0;
          amb_loop_en <= 1'b0;
        end
        default:
        begin
          prox_loop_en <= prox_loop_en;
          amb_loop_en <= amb_loop_en;
        end
      endcase
    end
  end

  // Software reset pulse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      soft_reset_pulse <= 1'b0;
    else
      soft_reset_pulse <= accept && cmd_code == scm_pkg::SOFT_RESET_CMD;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Forced measurement sequencer
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      scm_pkg::SCM_IDLE:
      begin
        if (accept)
        begin
          if (cmd_code == scm_pkg::SINGLE_PROXIMITY_CMD || cmd_code == scm_pkg::SINGLE_BOTH_CMD)
            state_nxt = scm_pkg::SCM_PROX;
          else if (cmd_code == scm_pkg::SINGLE_AMBIENT_CMD)
            state_nxt = scm_pkg::SCM_AMB;
          else
            state_nxt = scm_pkg::SCM_DONE;
        end
      end
      scm_pkg::SCM_PROX:
      begin
        if (meas_done)
          state_nxt = err_seen ? scm_pkg::SCM_ERR : (both_r ? scm_pkg::SCM_AMB : scm_pkg::SCM_DONE);
      end
      scm_pkg::SCM_AMB:
      begin
        if (meas_done)
          state_nxt = err_seen ? scm_pkg::SCM_ERR : scm_pkg::SCM_DONE;
      end
      scm_pkg::SCM_DONE: state_nxt = scm_pkg::SCM_IDLE;
      scm_pkg::SCM_ERR: state_nxt = scm_pkg::SCM_IDLE;
      default: state_nxt = scm_pkg::SCM_IDLE;
    endcase
  end

  // State, both-pass flag and no-count flag for null and reset commands
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= scm_pkg::SCM_IDLE;
      both_r <= 1'b0;
      quiet_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (accept)
      begin
        both_r <= (cmd_code == scm_pkg::SINGLE_BOTH_CMD);
        quiet_r <= (cmd_code == scm_pkg::NULL_CMD || cmd_code == scm_pkg::SOFT_RESET_CMD);
      end
    end
  end

  assign prox_pass_req = (state_r == scm_pkg::SCM_PROX);
  assign amb_pass_req = (state_r == scm_pkg::SCM_AMB);

  // Overflow code, lowest channel first
  always_comb
  begin
    err_seen = (meas_saturated != 6'h00);
    if (meas_saturated[0]) err_code = scm_pkg::REPLY_PROX_CH1_SATURATED;
    else if (meas_saturated[1]) err_code = scm_pkg::REPLY_PROX_CH2_SATURATED;
    else if (meas_saturated[2]) err_code = scm_pkg::REPLY_PROX_CH3_SATURATED;
    else if (meas_saturated[3]) err_code = scm_pkg::REPLY_VISIBLE_SATURATED;
    else if (meas_saturated[4]) err_code = scm_pkg::REPLY_INFRARED_SATURATED;
    else err_code = scm_pkg::REPLY_AUX_SATURATED;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reply register and completion counter
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reply <= scm_pkg::REPLY_RESET;
      count_r <= 4'h0;
      err_hold_r <= 1'b0;
    end
    else if (invalid_setting)
    begin
      // The error flag wins over a clear in the same cycle
      reply <= scm_pkg::REPLY_INVALID_SETTING;
      err_hold_r <= 1'b1;
      if (accept && (cmd_code == scm_pkg::NULL_CMD || cmd_code == scm_pkg::SOFT_RESET_CMD))
        count_r <= 4'h0;
    end
    else if (accept && cmd_code == scm_pkg::NULL_CMD)
    begin
      reply <= scm_pkg::REPLY_RESET;
      count_r <= 4'h0;
      err_hold_r <= 1'b0;
    end
    else if (accept && cmd_code == scm_pkg::SOFT_RESET_CMD)
    begin
      reply <= scm_pkg::REPLY_RESET;
      count_r <= 4'h0;
      err_hold_r <= 1'b0;
    end
    else if ((state_r == scm_pkg::SCM_PROX || state_r == scm_pkg::SCM_AMB) && meas_done && err_seen && !err_hold_r)
    begin
      reply <= err_code;
      err_hold_r <= 1'b1;
    end
    // Null and reset commands leave the counter at zero
    else if (state_r == scm_pkg::SCM_DONE && !err_hold_r && !quiet_r)
    begin
      reply <= {4'h0, count_r + 4'h1};
      count_r <= count_r + 4'h1;
    end
  end

endmodule
`default_nettype wire

// File: verif/scm_mailbox_props.sv
/* Port checker for the sensor command mailbox.
   Bound to scm_mailbox from the testbench top; one clock, reset active high. */
`timescale 1ns/100ps
`default_nettype none
module scm_mailbox_props (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic cmd_write, // Write strobe
  input wire logic [7:0] cmd_code, // Code
  input wire logic [6:0] new_bus_address, // Address in
  input wire logic invalid_setting, // Invalid flag
  input wire logic [7:0] reply, // Reply
  input wire logic [6:0] bus_address, // Address out
  input wire logic prox_pass_req, // Prox request
  input wire logic amb_pass_req, // Ambient request
  input wire logic prox_loop_en, // Prox loop
  input wire logic amb_loop_en, // Ambient loop
  input wire logic soft_reset_pulse, // Reset pulse
  input wire logic busy // Busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic take;
  // A command is accepted only when idle
  assign take = cmd_write && !busy;
  ////////////////////////////////////////////////////////////////////////////
  take_sets_busy_a: assert property (take |=> busy) else $error("accepted write left busy low");
  null_clears_a: assert property (take && cmd_code == 8'h00 && !invalid_setting |=> reply == 8'h00)
    else $error("null kept reply");
  null_quiet_a: assert property (take && cmd_code == 8'h00 && !invalid_setting ##1 !invalid_setting |=> reply == 8'h00)
    else $error("null counted");
  soft_reset_a: assert property (take && cmd_code == 8'h01 |-> ##[1:2] soft_reset_pulse) else $error("no reset");
  addr_load_a: assert property (take && cmd_code == 8'h02 |-> ##[1:2] bus_address == new_bus_address)
    else $error("address not taken");
  prox_req_a: assert property (take && cmd_code == 8'h05 |=> prox_pass_req && !amb_pass_req) else $error("no prox");
  amb_req_a: assert property (take && cmd_code == 8'h06 |=> amb_pass_req && !prox_pass_req) else $error("no amb");
  both_first_a: assert property (take && cmd_code == 8'h07 |=> prox_pass_req && !amb_pass_req) else $error("order");
  loops_start_a: assert property (take && cmd_code == 8'h0f |-> ##[1:2] prox_loop_en && amb_loop_en)
    else $error("loops not started");
  nibble_ok_a: assert property (reply[7:4] == 4'h0 || reply[7:4] == 4'h8) else $error("bad upper nibble");
  error_held_a: assert property (reply == 8'h80 && !busy && !cmd_write |=> reply == 8'h80) else $error("lost");
  invalid_set_a: assert property (invalid_setting |=> reply == 8'h80) else $error("invalid not shown");
endmodule
`default_nettype wire

// File: verif/scm_meas_model.sv
/* Measurement engine stand-in answering pass requests with a done pulse.
   Assumes requests are held until done; delay and flags come from the bench. */
`timescale 1ns/100ps
`default_nettype none
module scm_meas_model (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic prox_pass_req, // Prox pass wanted
  input wire logic amb_pass_req, // Ambient pass wanted
  input wire logic [3:0] delay, // Cycles before done
  input wire logic [5:0] sat, // Flags given with done
  output logic meas_done, // Done pulse
  output logic [5:0] meas_saturated // Flags, inverted outside done
);
  logic [3:0] cnt_r;
  // Flags mean nothing outside done, so show their inverse there
  assign meas_saturated = meas_done ? sat : ~sat;
  // Count request cycles, then pulse done once
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 4'h0;
      meas_done <= 1'b0;
    end
    else
    begin
      meas_done <= 1'b0;
      if ((prox_pass_req || amb_pass_req) && !meas_done)
      begin
        meas_done <= (cnt_r == delay);
        cnt_r <= (cnt_r == delay) ? 4'h0 : cnt_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

// File: verif/test_sensor_command_mailbox.sv
/* Self-checking bench for scm_mailbox with a measurement engine model.
   Assumes scm_pkg, the mailbox, the model and the checker are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module test_sensor_command_mailbox;
  logic clk, rst, cmd_write, invalid_setting, meas_done, err, pl, al;
  logic prox_pass_req, amb_pass_req, prox_loop_en, amb_loop_en, soft_reset_pulse, busy;
  logic [7:0] cmd_code, host_value_box, reply, readback_box, rb, rep;
  logic [6:0] new_bus_address, bus_address, adr;
  logic [5:0] meas_saturated, sat;
  logic [3:0] delay, cnt;
  logic [4:0] x;
  logic [7:0] prm [32];
  logic [24:0] notes [$];
  logic [7:0] tbl [16] = '{8'h05, 8'h06, 8'h07, 8'h0d, 8'h0e, 8'h0f, 8'h09, 8'h0a, 8'h0b, 8'h03, 8'h04, 8'h08,
    8'h0c, 8'h10, 8'h1f, 8'h02};
  int mismatches, tests_run;
  scm_mailbox scm_mailbox_i (.clk(clk), .rst(rst), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .host_value_box(host_value_box), .new_bus_address(new_bus_address), .invalid_setting(invalid_setting),
    .meas_done(meas_done), .meas_saturated(meas_saturated), .reply(reply), .readback_box(readback_box),
    .bus_address(bus_address), .prox_pass_req(prox_pass_req), .amb_pass_req(amb_pass_req),
    .prox_loop_en(prox_loop_en), .amb_loop_en(amb_loop_en), .soft_reset_pulse(soft_reset_pulse), .busy(busy));
  scm_meas_model scm_meas_model_i (.clk(clk), .rst(rst), .prox_pass_req(prox_pass_req), .amb_pass_req(amb_pass_req),
    .delay(delay), .sat(sat), .meas_done(meas_done), .meas_saturated(meas_saturated));
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [24:0] seen, input logic [24:0] want);
    tests_run++;
    if (seen !== want)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // Note the expected outcome, issue the command, wait for idle
  task automatic run(input logic [7:0] c, input logic [7:0] v, input logic [5:0] s);
    int w;
    sat = s;
    delay = 4'($urandom_range(5));
    if (c[7:5] == scm_pkg::OP_SET) prm[c[4:0]] = v;
    if (c[7:5] == scm_pkg::OP_AND) prm[c[4:0]] &= v;
    if (c[7:5] == scm_pkg::OP_OR) prm[c[4:0]] |= v;
    if (c[7]) rb = prm[c[4:0]];
    if (c == 8'h02) adr = new_bus_address;
    if (c == 8'h0d || c == 8'h0f) pl = 1;
    if (c == 8'h0e || c == 8'h0f) al = 1;
    if (c == 8'h09 || c == 8'h0b || c == 8'h01) pl = 0;
    if (c == 8'h0a || c == 8'h0b || c == 8'h01) al = 0;
    if (c <= 8'h01)
      {cnt, err, rep} = 0;
    else if (!err && s != 0)
    begin
      err = 1;
      for (int i = 5; i >= 0; i--)
        if (s[i]) rep = (i < 3) ? 8'h88 + 8'(i) : 8'h89 + 8'(i);
    end
    else if (!err)
    begin
      cnt++;
      rep = {4'h0, cnt};
    end
    notes.push_back({rep, rb, adr, pl, al});
    cmd_code = c;
    host_value_box = v;
    cmd_write = 1;
    @(posedge clk);
    #2 cmd_write = 0;
    for (w = 0; busy !== 1'b0 && w < 200; w++)
    begin
      @(posedge clk);
      #2;
    end
  endtask
  // Take the oldest note off the queue whenever a command finishes
  always @(negedge busy)
  begin
    #1;
    if (!rst && notes.size() != 0)
      check({reply, readback_box, bus_address, prox_loop_en, amb_loop_en}, notes.pop_front());
  end
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  initial
  begin
    #1500000;
    mismatches++;
    give_verdict;
  end
  initial
  begin
    {cmd_write, cmd_code, host_value_box, invalid_setting, sat, delay} = 0;
    rst = 1;
    {cnt, err, pl, al, rb, rep} = 0;
    new_bus_address = 7'h11;
    adr = 7'h5a;
    void'($urandom(32'h9b30e86d));
    repeat (2) @(posedge clk);
    #2 rst = 0;
    run(8'h00, 8'h00, 6'h0);
    for (int i = 0; i < 8; i++)
    begin
      x = 5'($urandom);
      run({scm_pkg::OP_SET, x}, 8'($urandom), 6'h0);
      run({scm_pkg::OP_AND, x}, 8'($urandom), 6'h0);
      run({scm_pkg::OP_OR, x}, 8'($urandom), 6'h0);
      run({scm_pkg::OP_QUERY, x}, 8'($urandom), 6'h0);
    end
    for (int i = 0; i < 32; i++)
    begin
      new_bus_address = 7'($urandom);
      run(tbl[i % 16], 8'h00, 6'h0);
    end
    for (int i = 0; i < 6; i++)
    begin
      run((i < 3) ? 8'h05 : 8'h06, 8'h00, 6'h1 << i);
      run(8'h00, 8'h00, 6'h0);
      check({17'h0, reply}, 25'h0);
    end
    invalid_setting = 1;
    @(posedge clk);
    #2 invalid_setting = 0;
    {err, rep} = {1'b1, 8'h80};
    run(8'h07, 8'h00, 6'h0);
    run(8'h0f, 8'h00, 6'h0);
    run(8'h01, 8'h00, 6'h0);
    repeat (40000) @(posedge clk);
    #2 run(8'h0d, 8'h00, 6'h0);
    check(25'(notes.size()), 25'h0);
    give_verdict;
  end
endmodule
bind scm_mailbox scm_mailbox_props scm_mailbox_props_i (.clk(clk), .rst(rst), .cmd_write(cmd_write),
  .cmd_code(cmd_code), .new_bus_address(new_bus_address), .invalid_setting(invalid_setting), .reply(reply),
  .bus_address(bus_address), .prox_pass_req(prox_pass_req), .amb_pass_req(amb_pass_req),
  .prox_loop_en(prox_loop_en), .amb_loop_en(amb_loop_en), .soft_reset_pulse(soft_reset_pulse), .busy(busy));
`default_nettype wire
